// ---- design/irq_aggregation_pkg.sv ----
`default_nettype none
package irq_aggregation_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int NUM_IRQ       = 48;
    localparam int NUM_DRQ       = 32;
    localparam int NUM_RELOC     = 8;
    localparam int RELOC_PER_REG = 4;
    localparam int RELOC_FIRST   = 3;
    localparam int SEL_W         = 8;
    localparam int SEL_EN_BIT    = 7;
    localparam int POOL_W        = 64;
    localparam int AUX_W         = 8;
    localparam int SERIAL_HI_LSB = 8;
    localparam int DRQ_RX_LSB    = 0;
    localparam int DRQ_TX_LSB    = 8;
    localparam int DRQ_BT_LSB    = 16;

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [11:0] ADDR_MAP_SEL = 12'h000;
    localparam logic [11:0] ADDR_RELOC0  = 12'h004;
    localparam logic [11:0] ADDR_RELOC1  = 12'h008;
    localparam logic [11:0] ADDR_DRQ0    = 12'h010;
    localparam logic [11:0] ADDR_DRQ1    = 12'h014;
    localparam logic [11:0] ADDR_DRQEXT  = 12'h018;
    localparam logic [11:0] ADDR_EXC02   = 12'h100;
    localparam logic [11:0] ADDR_MON     = 12'h200;
    localparam logic [3:0]  MON_PAGE     = 4'h2;
    localparam logic [5:0]  MON_LAST     = 6'h2f;

    // ****************************************
    // reset values and extended selector lines
    // ****************************************
    localparam logic        MAP_RST   = 1'b0;
    localparam logic [31:0] REG_RST   = 32'h0000_0000;
    localparam logic [31:0] EXT_LINES = 32'hcf00_0c00;
    localparam logic [4:0]  EXT_IDX [8] = '{5'h0a, 5'h0b, 5'h18, 5'h19,
                                            5'h1a, 5'h1b, 5'h1e, 5'h1f};

    // peripheral request lines, one bit per source
    typedef struct packed {
        logic        clock_fail;
        logic        soft_watchdog;
        logic        low_voltage;
        logic [2:0]  wave_gen;
        logic [2:0]  motor_emergency_stop;
        logic [7:0]  ext_pin_lo;
        logic [23:0] ext_pin_hi;
        logic        dual_timer;
        logic [2:0]  quad_count;
        logic [15:0] serial_rx;
        logic [15:0] serial_tx;
        logic [8:0]  pulse_generator;
        logic [5:0]  osc_watch;
        logic [2:0]  adc;
        logic        lcd;
        logic [2:0]  free_run;
        logic [2:0]  capture;
        logic [2:0]  compare;
        logic [15:0] base_timer;
        logic [1:0]  can;
        logic [1:0]  ethernet;
        logic [3:0]  usb;
        logic [1:0]  consumer_ctrl;
        logic [7:0]  dma_controller;
        logic        flash_ready;
    } periph_req_t;

endpackage : irq_aggregation_pkg
`default_nettype wire

// ---- design/irq_aggregation_dma_routing.sv ----
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
module irq_aggregation_dma_routing (
    input  wire logic                            clock,
    input  wire logic                            sys_rst,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [11:0]                     paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire irq_aggregation_pkg::periph_req_t periph,
    input  wire logic                            nonmaskable_pin_n,
    input  wire logic                            hw_watchdog_irq,
    output logic      [47:0]                     irq_out,
    output logic                                 nmi_out,
    output logic      [31:0]                     dma_request,
    output logic      [7:0]                      dma_request_aux
);

    // ****************************************
    // helpers
    // ****************************************

    // place the eight extended sources on their dma line positions
    function automatic logic [31:0] spread(input logic [7:0] src);
        logic [31:0] r;
        r = '0;
        for (int j = 0; j < 8; j++)
        begin
            r[irq_aggregation_pkg::EXT_IDX[j]] = src[j];
        end
        return r;
    endfunction : spread

    // collect the eight extended line positions back into a byte
    function automatic logic [7:0] gather(input logic [31:0] v);
        logic [7:0] r;
        r = '0;
        for (int j = 0; j < 8; j++)
        begin
            r[j] = v[irq_aggregation_pkg::EXT_IDX[j]];
        end
        return r;
    endfunction : gather

    // one selector byte: enable bit and pool index
    function automatic logic pick(input logic [63:0] pool,
                                  input logic [7:0]  sel);
        return sel[irq_aggregation_pkg::SEL_EN_BIT] & pool[sel[5:0]];
    endfunction : pick

    // ****************************************
    // registers
    // ****************************************
    logic        map_q;
    logic [31:0] reloc0_q;
    logic [31:0] reloc1_q;
    logic [31:0] sel0_q;
    logic [31:0] sel1_q;
    logic [31:0] ext_q;
    logic [31:0] rdata_q;
    logic        slverr_q;
    logic [47:0] irq_q;
    logic        nmi_q;
    logic [31:0] drq_q;
    logic [7:0]  aux_q;

    // ****************************************
    // dma routing
    // ****************************************
    logic [31:0] drq_base;
    logic [31:0] alt_line;
    logic [31:0] ext_on;
    logic [31:0] chosen;
    logic [31:0] base_taken;
    logic [7:0]  alt_taken;
    logic [31:0] drq_d;
    logic [7:0]  aux_d;
    logic [15:0] rx_c;
    logic [15:0] tx_c;
    logic [15:0] bt_c;

    // candidate lines, extended sources are serial rx 8..15
    assign drq_base = {periph.base_timer, periph.serial_tx[7:0],
                       periph.serial_rx[7:0]};
    assign alt_line = spread(periph.serial_rx[15:8]);
    // extended selector lines
    // only the eight fixed lines honour the extended bits
    assign ext_on   = ext_q & irq_aggregation_pkg::EXT_LINES;
    assign chosen   = (ext_on & alt_line) | (~ext_on & drq_base);
    // cpu or dma steering
    // a request steered to dma is hidden from its interrupt input
    assign drq_d      = sel0_q & chosen;
    assign base_taken = sel0_q & ~ext_on;
    assign alt_taken  = gather(sel0_q & ext_on);
    assign aux_d      = sel1_q[7:0] & periph.serial_tx[15:8];

    // cpu-side copies of the steerable sources
    assign rx_c[7:0]  = periph.serial_rx[7:0]
                      & ~base_taken[irq_aggregation_pkg::DRQ_RX_LSB +: 8];
    assign tx_c[7:0]  = periph.serial_tx[7:0]
                      & ~base_taken[irq_aggregation_pkg::DRQ_TX_LSB +: 8];
    assign bt_c       = periph.base_timer
                      & ~base_taken[irq_aggregation_pkg::DRQ_BT_LSB +: 16];
    assign rx_c[15:8] = periph.serial_rx[15:8] & ~alt_taken;
    assign tx_c[15:8] = periph.serial_tx[15:8] & ~sel1_q[7:0];

    // ****************************************
    // relocated source pool
    // ****************************************
    logic [63:0] pool;
    logic [7:0]  rsel  [8];
    logic [7:0]  reloc;

    assign pool = 64'({periph.adc, periph.compare, periph.capture,
                       periph.free_run, |periph.ext_pin_hi,
                       |periph.ext_pin_lo, periph.dual_timer,
                       periph.quad_count, periph.motor_emergency_stop,
                       periph.wave_gen, tx_c, rx_c});

    for (genvar i = 0; i < irq_aggregation_pkg::NUM_RELOC; i++)
    begin : g_reloc
        if (i < irq_aggregation_pkg::RELOC_PER_REG)
        begin : g_lo
            assign rsel[i] = reloc0_q[i*8 +: 8];
        end
        else
        begin : g_hi
            assign rsel[i] = reloc1_q[(i-4)*8 +: 8];
        end
        assign reloc[i] = pick(pool, rsel[i]);
    end

    // ****************************************
    // contributing lines per input, both maps
    // ****************************************
    logic [31:0] mon0 [48];
    logic [31:0] mon1 [48];
    logic [31:0] mon_w [48];
    logic [47:0] irq_d;

    assign mon0[0]  = 32'(periph.clock_fail);
    assign mon0[1]  = 32'(periph.soft_watchdog);
    assign mon0[2]  = 32'(periph.low_voltage);
    assign mon0[3]  = 32'({periph.motor_emergency_stop, periph.wave_gen});
    assign mon0[4]  = 32'(periph.ext_pin_lo);
    assign mon0[5]  = 32'(periph.ext_pin_hi);
    assign mon0[6]  = 32'({periph.quad_count, periph.dual_timer});
    for (genvar k = 0; k < 8; k++)
    begin : g_ser0
        assign mon0[7+2*k] = 32'({rx_c[k+8], rx_c[k]});
        assign mon0[8+2*k] = 32'({tx_c[k+8], tx_c[k]});
    end
    assign mon0[23] = 32'(periph.pulse_generator);
    assign mon0[24] = 32'(periph.osc_watch);
    assign mon0[25] = 32'(periph.adc[0]);
    assign mon0[26] = 32'(periph.adc[1]);
    assign mon0[27] = 32'({periph.lcd, periph.adc[2]});
    assign mon0[28] = 32'(periph.free_run);
    assign mon0[29] = 32'(periph.capture);
    assign mon0[30] = 32'(periph.compare);
    assign mon0[31] = 32'(bt_c[7:0]);
    assign mon0[32] = 32'({periph.ethernet[0], periph.can[0]});
    assign mon0[33] = 32'({periph.ethernet[1], periph.can[1]});
    assign mon0[34] = 32'(periph.usb[0]);
    assign mon0[35] = 32'(periph.usb[1]);
    assign mon0[36] = 32'({periph.consumer_ctrl[0], periph.usb[2]});
    assign mon0[37] = 32'({periph.consumer_ctrl[1], periph.usb[3]});
    for (genvar k = 0; k < 8; k++)
    begin : g_dma0
        assign mon0[38+k] = 32'(periph.dma_controller[k]);
    end
    assign mon0[46] = 32'(bt_c[15:8]);
    assign mon0[47] = 32'(periph.flash_ready);

    // relocated map; relocated inputs report the picked line in bit 0
    for (genvar k = 0; k < 3; k++)
    begin : g_same
        assign mon1[k] = mon0[k];
    end
    for (genvar k = 0; k < irq_aggregation_pkg::NUM_RELOC; k++)
    begin : g_rel1
        assign mon1[irq_aggregation_pkg::RELOC_FIRST+k] = 32'(reloc[k]);
    end
    assign mon1[11] = 32'({tx_c[8], rx_c[8],
                           periph.motor_emergency_stop[0],
                           periph.wave_gen[0]});
    assign mon1[12] = mon0[4];
    assign mon1[13] = mon0[5];
    assign mon1[14] = 32'({periph.quad_count[0], periph.dual_timer});
    for (genvar k = 0; k < 4; k++)
    begin : g_ser1
        assign mon1[15+k] = 32'({tx_c[k], rx_c[k]});
    end
    assign mon1[19] = 32'(rx_c[4]);
    assign mon1[20] = 32'(tx_c[4]);
    assign mon1[21] = 32'(rx_c[5]);
    assign mon1[22] = 32'(tx_c[5]);
    assign mon1[23] = mon0[23];
    assign mon1[24] = mon0[24];
    assign mon1[25] = 32'({tx_c[9], rx_c[9], periph.adc[0]});
    assign mon1[26] = 32'({tx_c[10], rx_c[10], periph.adc[1]});
    assign mon1[27] = 32'({tx_c[11], rx_c[11], periph.lcd, periph.adc[2]});
    for (genvar u = 0; u < 3; u++)
    begin : g_unit
        assign mon1[28+u] = 32'({periph.compare[u], periph.capture[u],
                                 periph.free_run[u]});
    end
    assign mon1[31] = mon0[31];
    assign mon1[32] = 32'({tx_c[12], rx_c[12], periph.ethernet[0],
                           periph.can[0]});
    assign mon1[33] = 32'({tx_c[13], rx_c[13], periph.ethernet[1],
                           periph.can[1]});
    for (genvar k = 34; k < 38; k++)
    begin : g_usb
        assign mon1[k] = mon0[k];
    end
    assign mon1[38] = 32'(periph.dma_controller);
    // timer units 1, 2 with serial 14, 15
    assign mon1[39] = 32'({tx_c[14], rx_c[14],
                           periph.motor_emergency_stop[1],
                           periph.wave_gen[1]});
    assign mon1[40] = 32'({tx_c[15], rx_c[15],
                           periph.motor_emergency_stop[2],
                           periph.wave_gen[2]});
    assign mon1[41] = 32'(periph.quad_count[1]);
    assign mon1[42] = 32'(rx_c[6]);
    assign mon1[43] = 32'(tx_c[6]);
    assign mon1[44] = 32'(rx_c[7]);
    assign mon1[45] = 32'(tx_c[7]);
    assign mon1[46] = mon0[46];
    assign mon1[47] = 32'({periph.flash_ready, periph.quad_count[2]});

    // each input is the OR of its lines
    for (genvar n = 0; n < irq_aggregation_pkg::NUM_IRQ; n++)
    begin : g_or
        assign mon_w[n] = map_q ? mon1[n] : mon0[n];
        assign irq_d[n] = |mon_w[n];
    end

    // ****************************************
    // apb slave, zero wait states
    // ****************************************
    logic        setup;
    logic        wr_en;
    logic [5:0]  mon_idx;
    logic        hit_map;
    logic        hit_r0;
    logic        hit_r1;
    logic        hit_s0;
    logic        hit_s1;
    logic        hit_ext;
    logic        hit_exc;
    logic        hit_mon;
    logic        mapped;
    logic [31:0] rd_word;

    assign setup   = psel & ~penable;
    assign wr_en   = psel & penable & pwrite;
    assign mon_idx = paddr[7:2];
    assign hit_map = paddr == irq_aggregation_pkg::ADDR_MAP_SEL;
    assign hit_r0  = paddr == irq_aggregation_pkg::ADDR_RELOC0;
    assign hit_r1  = paddr == irq_aggregation_pkg::ADDR_RELOC1;
    assign hit_s0  = paddr == irq_aggregation_pkg::ADDR_DRQ0;
    assign hit_s1  = paddr == irq_aggregation_pkg::ADDR_DRQ1;
    assign hit_ext = paddr == irq_aggregation_pkg::ADDR_DRQEXT;
    assign hit_exc = paddr == irq_aggregation_pkg::ADDR_EXC02;
    assign hit_mon = (paddr[11:8] == irq_aggregation_pkg::MON_PAGE)
                   && (paddr[1:0] == 2'h0)
                   && (mon_idx <= irq_aggregation_pkg::MON_LAST);
    assign mapped  = hit_map | hit_r0 | hit_r1 | hit_s0 | hit_s1
                   | hit_ext | hit_exc | hit_mon;

    // read mux, pure selection with no side effect
    // nmi vector and every input visible
    assign rd_word = hit_map ? 32'(map_q)
                   : hit_r0  ? reloc0_q
                   : hit_r1  ? reloc1_q
                   : hit_s0  ? sel0_q
                   : hit_s1  ? sel1_q
                   : hit_ext ? ext_q
                   : hit_exc ? 32'({hw_watchdog_irq, ~nonmaskable_pin_n})
                   : hit_mon ? mon_w[mon_idx]
                   : 32'h0000_0000;

    // answer latched in setup, so pready can stand high
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rdata_q  <= irq_aggregation_pkg::REG_RST;
            slverr_q <= 1'b0;
        end
        else if (setup)
        begin
            rdata_q  <= pwrite ? irq_aggregation_pkg::REG_RST : rd_word;
            slverr_q <= ~mapped | (pwrite & (hit_exc | hit_mon));
        end
    end

    // reset routes to cpu, compatible map
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            map_q    <= irq_aggregation_pkg::MAP_RST;
            reloc0_q <= irq_aggregation_pkg::REG_RST;
            reloc1_q <= irq_aggregation_pkg::REG_RST;
            sel0_q   <= irq_aggregation_pkg::REG_RST;
            sel1_q   <= irq_aggregation_pkg::REG_RST;
            ext_q    <= irq_aggregation_pkg::REG_RST;
        end
        else if (wr_en)
        begin
            if (hit_map) map_q    <= pwdata[0];
            if (hit_r0)  reloc0_q <= pwdata;
            if (hit_r1)  reloc1_q <= pwdata;
            if (hit_s0)  sel0_q   <= pwdata;
            if (hit_s1)  sel1_q   <= {24'h0, pwdata[7:0]};
            if (hit_ext) ext_q    <= pwdata & irq_aggregation_pkg::EXT_LINES;
        end
    end

    // outputs registered: one cycle from source to core
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            irq_q <= '0;
            nmi_q <= 1'b0;
            drq_q <= '0;
            aux_q <= '0;
        end
        else
        begin
            irq_q <= irq_d;
            nmi_q <= ~nonmaskable_pin_n | hw_watchdog_irq;
            drq_q <= drq_d;
            aux_q <= aux_d;
        end
    end

    assign prdata          = rdata_q;
    assign pslverr         = slverr_q;
    assign pready          = 1'b1;
    assign irq_out         = irq_q;
    assign nmi_out         = nmi_q;
    assign dma_request     = drq_q;
    assign dma_request_aux = aux_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    chk_nmi_combine: assert property (
        !nonmaskable_pin_n |=> nmi_out) else $error("nmi pin lost");
    chk_dma_single: assert property (
        (!map_q && periph.dma_controller[3]) |=> irq_out[41])
        else $error("dma channel 3 not on input 41");
    chk_dma_merged: assert property (
        (map_q && |periph.dma_controller) |=> irq_out[38])
        else $error("dma OR missing on input 38");
    chk_unit_input: assert property (
        (map_q && periph.free_run[1]) |=> irq_out[29])
        else $error("timer unit 1 not on input 29");
    chk_kind_input: assert property (
        (!map_q && periph.capture[2]) |=> irq_out[29])
        else $error("capture not on input 29");
    chk_route_dma: assert property (
        (!map_q && sel0_q[0] && !ext_on[0] && periph.serial_rx[0]
         && !periph.serial_rx[8]) |=> (dma_request[0] && !irq_out[7]))
        else $error("steered request still reaches cpu");
    chk_ext_alt: assert property (
        (ext_q[10] && sel0_q[10] && periph.serial_rx[8])
        |=> dma_request[10]) else $error("extended source not routed");
    chk_serial_reloc: assert property (
        (map_q && !sel1_q[4] && periph.serial_tx[4] && !sel0_q[12])
        |=> irq_out[20]) else $error("serial 4 tx not on input 20");
    chk_read_pure: assert property (
        (psel && !pwrite) |=> ($stable(sel0_q) && $stable(map_q)))
        else $error("read changed a register");
    chk_exc_read: assert property (
        (setup && !pwrite && paddr == irq_aggregation_pkg::ADDR_EXC02)
        |=> prdata[0] == $past(~nonmaskable_pin_n))
        else $error("nmi batch read wrong");
    chk_reset_dflt: assert property (disable iff (1'b0)
        $past(sys_rst) |-> (sel0_q == '0 && !map_q))
        else $error("reset defaults wrong");

    cov_reloc_mode: cover property (map_q && |irq_out);
    cov_dma_route:  cover property (|dma_request);
    cov_bad_addr:   cover property (psel && penable && pslverr);

endmodule : irq_aggregation_dma_routing
`default_nettype wire

// ---- tb/core_sink_model.sv ----
`default_nettype none
// ****************************************
// core side: pending latches
// ****************************************
module core_sink_model (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [47:0] irq_in,
    input  wire logic        nmi_in,
    output logic      [47:0] pending_q,
    output logic             nmi_seen_q
);
    timeunit 1ns;
    timeprecision 1ps;

    // level requests set sticky pending bits, as a core would
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pending_q  <= '0;
            nmi_seen_q <= 1'b0;
        end
        else
        begin
            pending_q  <= pending_q | irq_in;
            nmi_seen_q <= nmi_seen_q | nmi_in;
        end
    end
endmodule : core_sink_model
`default_nettype wire

// ---- tb/irq_aggregation_dma_routing_tb.sv ----
`default_nettype none
module irq_aggregation_dma_routing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // stimulus and checking
    // ****************************************
    localparam logic [47:0] M1 = 48'hffc3_fe70_0000;
    localparam logic [47:0] M0 = 48'hffc0_f000_0000;
    logic        clock, sys_rst, psel, penable, pwrite, err, md;
    logic        pin_n, wdog, pready, pslverr, nmi_out, nmi_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, drq, rd;
    logic [47:0] irq, pend, e;
    logic [7:0]  aux;
    logic [159:0] r;
    irq_aggregation_pkg::periph_req_t p;
    int          n_mismatch = 0;
    int          n_compared = 0;

    irq_aggregation_dma_routing dut (.clock(clock), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph(p), .nonmaskable_pin_n(pin_n),
        .hw_watchdog_irq(wdog), .irq_out(irq), .nmi_out(nmi_out),
        .dma_request(drq), .dma_request_aux(aux));
    core_sink_model sink (.clock(clock), .sys_rst(sys_rst), .irq_in(irq),
        .nmi_in(nmi_out), .pending_q(pend), .nmi_seen_q(nmi_seen));

    task automatic check(input string what, input logic [47:0] seen,
                         input logic [47:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // one transfer; an idle edge first so psel never toggles twice at once
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge clock);
            if (pready === 1'b1)
                break;
        end
        if (k == 16)
        begin
            n_mismatch++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // outputs are registered: two edges leave margin for one cycle
    task automatic settle;
        repeat (2) @(posedge clock);
        #1;
    endtask : settle

    function automatic logic [47:0] expect_irq(input logic rel,
        input irq_aggregation_pkg::periph_req_t v);
        logic [47:0] x;
        x = '0;
        x[31] = |v.base_timer[7:0];
        x[46] = |v.base_timer[15:8];
        if (rel)
        begin
            x[22:20] = {v.serial_tx[5], v.serial_rx[5], v.serial_tx[4]};
            x[25] = v.serial_tx[9] | v.serial_rx[9] | v.adc[0];
            x[26] = v.serial_tx[10] | v.serial_rx[10] | v.adc[1];
            x[27] = v.serial_tx[11] | v.serial_rx[11] | v.lcd | v.adc[2];
            x[32] = v.serial_tx[12] | v.serial_rx[12] | v.ethernet[0]
                  | v.can[0];
            x[33] = v.serial_tx[13] | v.serial_rx[13] | v.ethernet[1]
                  | v.can[1];
            x[39] = v.serial_tx[14] | v.serial_rx[14]
                  | v.motor_emergency_stop[1] | v.wave_gen[1];
            x[40] = v.serial_tx[15] | v.serial_rx[15]
                  | v.motor_emergency_stop[2] | v.wave_gen[2];
            x[30:28] = v.free_run | v.capture | v.compare;
            x[38] = |v.dma_controller;
            x[41] = v.quad_count[1];
            x[45:42] = {v.serial_tx[7], v.serial_rx[7],
                        v.serial_tx[6], v.serial_rx[6]};
            x[47] = v.quad_count[2] | v.flash_ready;
        end
        else
        begin
            x[30:28] = {|v.compare, |v.capture, |v.free_run};
            x[45:38] = v.dma_controller;
            x[47] = v.flash_ready;
        end
        return x;
    endfunction : expect_irq

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial
    begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pin_n, wdog, p} = {2'b10, 140'h0};
        void'($urandom(32'hb471));
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        apb(1'b0, irq_aggregation_pkg::ADDR_MAP_SEL, '0);
        check("map reset", 48'(rd), '0);
        apb(1'b0, irq_aggregation_pkg::ADDR_DRQ0, '0);
        check("select reset", 48'(rd), '0);
        apb(1'b1, irq_aggregation_pkg::ADDR_DRQEXT, '1);
        apb(1'b0, irq_aggregation_pkg::ADDR_DRQEXT, '0);
        check("ext lines", 48'(rd), 48'(irq_aggregation_pkg::EXT_LINES));
        apb(1'b1, irq_aggregation_pkg::ADDR_DRQEXT, '0);
        apb(1'b0, 12'h020, '0);
        check("unmapped", 48'(err), 48'h1);
        // base timer 0 goes to dma, then back to the cpu
        apb(1'b1, irq_aggregation_pkg::ADDR_DRQ0, 32'h0001_0000);
        p.base_timer <= 16'h0001;
        settle();
        check("to dma", 48'({drq[16], irq[31]}), 48'h2);
        apb(1'b1, irq_aggregation_pkg::ADDR_DRQ0, '0);
        settle();
        check("to cpu", 48'({drq[16], irq[31]}), 48'h1);
        @(posedge clock);
        {pin_n, wdog} <= 2'b01;
        settle();
        check("nmi", 48'(nmi_out), 48'h1);
        // reading twice shows the flags were not cleared
        repeat (2)
        begin
            apb(1'b0, irq_aggregation_pkg::ADDR_EXC02, '0);
            check("nmi batch", 48'(rd[1:0]), 48'h3);
        end
        check("sink nmi", 48'({nmi_seen, pend[31]}), 48'h3);
        // extended line 10, aux line 0 and input 3 picking serial rx 0
        apb(1'b1, irq_aggregation_pkg::ADDR_DRQEXT, 32'h0000_0400);
        apb(1'b1, irq_aggregation_pkg::ADDR_DRQ0, 32'h0000_0400);
        apb(1'b1, irq_aggregation_pkg::ADDR_DRQ1, 32'h0000_0001);
        apb(1'b1, irq_aggregation_pkg::ADDR_RELOC0, 32'h0000_0080);
        apb(1'b1, irq_aggregation_pkg::ADDR_MAP_SEL, 32'h0000_0001);
        p.serial_rx <= 16'h0101;
        p.serial_tx <= 16'h0100;
        settle();
        check("ext drq", 48'(drq[10]), 48'h1);
        check("aux drq", 48'({aux[0], irq[11]}), 48'h2);
        check("reloc pick", 48'(irq[3]), 48'h1);
        apb(1'b0, 12'h20c, '0);
        check("reloc batch", 48'(rd), 48'h1);
        // leave every selector clear for the random part
        apb(1'b1, irq_aggregation_pkg::ADDR_DRQEXT, '0);
        apb(1'b1, irq_aggregation_pkg::ADDR_DRQ0, '0);
        apb(1'b1, irq_aggregation_pkg::ADDR_DRQ1, '0);
        apb(1'b1, irq_aggregation_pkg::ADDR_RELOC0, '0);
        for (int i = 0; i < 40; i++)
        begin
            md = 1'($urandom);
            apb(1'b1, irq_aggregation_pkg::ADDR_MAP_SEL, {31'h0, md});
            r = {$urandom, $urandom, $urandom, $urandom, $urandom};
            p <= r[139:0];
            {pin_n, wdog} <= 2'($urandom);
            settle();
            e = expect_irq(md, p);
            if (md)
                check("rel", irq & M1, e);
            else
                check("cmp", irq & M0, e);
            check("nmi or", 48'(nmi_out), 48'(!pin_n | wdog));
        end
        final_report();
    end
endmodule : irq_aggregation_dma_routing_tb
`default_nettype wire
